//--- sscx_exec.sv
`timescale 1ns/1ps
// execution unit for right doubleword store, halfword store,
// word left shifts and signed set-less-than
module sscx_exec
  import sscx_pkg::*;
(
  input  wire logic         i_clk_sys,     // core clock
  input  wire logic         i_resetn,      // async reset, active low
  input  wire logic         i_valid,       // instruction valid
  input  wire logic [31:0]  i_instr,       // instruction word
  input  wire logic [63:0]  i_rs_data,     // first_source_reg / base value
  input  wire logic [63:0]  i_rt_data,     // second register value
  input  wire logic         i_big_endian,  // cpu_big_endian_flag
  input  wire logic         i_tlb_refill,  // translation refill fault
  input  wire logic         i_tlb_invalid, // translation invalid fault
  input  wire logic         i_tlb_mod,     // translation modified fault
  output logic      [4:0]   o_rs_idx,      // register read index one
  output logic      [4:0]   o_rt_idx,      // register read index two
  output logic              o_wb_en,       // register write pulse
  output logic      [4:0]   o_wb_idx,      // write index
  output logic      [63:0]  o_wb_data,     // write data
  output logic              o_mem_wr,      // memory store pulse
  output logic      [31:0]  o_mem_vaddr,   // effective address
  output logic      [3:0]   o_mem_len,     // access length in bytes
  output logic      [127:0] o_mem_data,    // quadword lane data
  output logic      [15:0]  o_mem_be,      // byte lane enables
  output logic              o_exc,         // exception pulse
  output sscx_exc_t         o_exc_code     // exception kind
);
  typedef struct packed {
    logic         rst_meta;
    logic         rst_sync;
    logic         wb_en;
    logic [4:0]   wb_idx;
    logic [63:0]  wb_data;
    logic         mem_wr;
    logic [31:0]  vaddr;
    logic [3:0]   len;
    logic [127:0] data;
    logic [15:0]  be;
    logic         exc;
    sscx_exc_t    exc_code;
  } sscx_state_t;

  sscx_state_t st_reg, st_next;
  logic [5:0]  opc, fn;
  logic [31:0] ea;
  logic [63:0] shl_res, slt_res;
  logic [4:0]  amt;
  logic [2:0]  bofs;
  logic        is_sdr, is_sh, is_sll, is_shift_left_word_var, is_slt, tlb_any;
  sscx_exc_t   tlb_code;

  // field decode
  assign opc      = i_instr[SSCX_OPC_LSB +: 6];                // see RULE2
  assign fn       = i_instr[5:0];
  assign o_rs_idx = i_instr[SSCX_BASE_LSB +: 5];               // see RULE2
  assign o_rt_idx = i_instr[SSCX_RT_LSB +: 5];                 // see RULE2
  assign is_sdr   = i_valid && (opc == SSCX_OP_SDWR);          // see RULE2
  assign is_sh    = i_valid && (opc == SSCX_OP_SHALF);
  assign is_sll   = i_valid && (opc == SSCX_OP_SPECIAL)
                    && (fn == SSCX_FN_SLLI);                   // see RULE10
  assign is_shift_left_word_var  = i_valid && (opc == SSCX_OP_SPECIAL)
                    && (fn == SSCX_FN_SHIFT_LEFT_WORD_VAR);
  assign is_slt   = i_valid && (opc == SSCX_OP_SPECIAL)
                    && (fn == SSCX_FN_SLTS);                   // see RULE13

  // effective address from low base word plus extended offset
  assign ea = i_rs_data[31:0]
              + {{16{i_instr[15]}}, i_instr[15:0]}; // see RULE3 see RULE8
  // byte offset within doubleword, mirrored for big-endian ordering
  assign bofs = ea[2:0] ^ {3{i_big_endian}};
  // count: field for immediate form, low five source bits for variable
  assign amt = is_shift_left_word_var ? i_rs_data[4:0]                        // see RULE12
                       : i_instr[SSCX_SA_LSB +: 5];            // see RULE10

  assign tlb_any  = i_tlb_refill | i_tlb_invalid | i_tlb_mod;
  // refill outranks invalid, which outranks modified
  assign tlb_code = i_tlb_refill  ? SSCX_EXC_REFILL :          // see RULE15
                    i_tlb_invalid ? SSCX_EXC_INVAL  : SSCX_EXC_MOD;

  sscx_shift_cmp u_alu (
    .i_src_s (i_rs_data),
    .i_src_t (i_rt_data),
    .i_amt   (amt),
    .o_shl   (shl_res),
    .o_slt   (slt_res)
  );

  // next-state: results registered one cycle after issue
  always_comb begin
    logic [63:0] lanes;
    logic [7:0]  bmask;
    lanes = 64'h0;
    bmask = 8'h0;
    st_next          = st_reg;
    st_next.rst_meta = 1'b1;
    st_next.rst_sync = st_reg.rst_meta;
    st_next.wb_en    = 1'b0;
    st_next.mem_wr   = 1'b0;
    st_next.exc      = 1'b0;
    st_next.exc_code = SSCX_EXC_NONE;
    if (is_sll || is_shift_left_word_var) begin
      st_next.wb_en   = 1'b1;
      st_next.wb_idx  = i_instr[SSCX_RD_LSB +: 5];
      st_next.wb_data = shl_res;                               // see RULE11
    end else if (is_slt) begin
      st_next.wb_en   = 1'b1;                                  // see RULE14
      st_next.wb_idx  = i_instr[SSCX_RD_LSB +: 5];
      st_next.wb_data = slt_res;
    end else if (is_sdr) begin
      // low register byte at addressed byte, upward to dword end
      lanes = i_rt_data << {bofs, 3'b000};                     // see RULE5
      bmask = 8'hff << bofs;                                   // see RULE4
      st_next.vaddr = ea;
      st_next.len   = SSCX_DWORD_LEN - {1'b0, bofs};           // see RULE7
      // the dword half of the quadword is picked by address bit 3
      if (ea[3] ^ i_big_endian) begin                          // see RULE7
        st_next.data = {lanes, 64'h0};
        st_next.be   = {bmask, 8'h00};
      end else begin
        st_next.data = {64'h0, lanes};
        st_next.be   = {8'h00, bmask};
      end
      // no alignment check at all on this path
      if (tlb_any) begin                                       // see RULE6
        st_next.exc      = 1'b1;
        st_next.exc_code = tlb_code;                           // see RULE15
      end else begin
        st_next.mem_wr = 1'b1;                                 // see RULE1
      end
    end else if (is_sh) begin
      st_next.vaddr = ea;
      st_next.len   = SSCX_HALF_LEN;
      st_next.data  = {112'h0, i_rt_data[15:0]}
                      << {ea[3:1] ^ {3{i_big_endian}}, 4'h0};  // see RULE8
      st_next.be    = 16'h0003 << {ea[3:1] ^ {3{i_big_endian}}, 1'b0};
      // alignment fault wins over translation faults
      if (ea[0]) begin
        st_next.exc      = 1'b1;
        st_next.exc_code = SSCX_EXC_ADEL;                      // see RULE9
      end else if (tlb_any) begin
        st_next.exc      = 1'b1;
        st_next.exc_code = tlb_code;                           // see RULE15
      end else begin
        st_next.mem_wr = 1'b1;
      end
    end
    // pulses are held low until the synchronised reset has released
    if (!st_reg.rst_sync) begin
      st_next.wb_en  = 1'b0;
      st_next.mem_wr = 1'b0;
      st_next.exc    = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_wb_en     = st_reg.wb_en;
  assign o_wb_idx    = st_reg.wb_idx;
  assign o_wb_data   = st_reg.wb_data;
  assign o_mem_wr    = st_reg.mem_wr;
  assign o_mem_vaddr = st_reg.vaddr;
  assign o_mem_len   = st_reg.len;
  assign o_mem_data  = st_reg.data;
  assign o_mem_be    = st_reg.be;
  assign o_exc       = st_reg.exc;
  assign o_exc_code  = st_reg.exc_code;
endmodule : sscx_exec

//--- sscx_pkg.sv
// Summary of operation
// RULE1: right doubleword store writes low register bytes
// RULE2: decode opcode 101101, base, data, offset fields
// RULE3: address is base plus sign-extended offset
// RULE4: only the containing doubleword, one to eight bytes
// RULE5: low register byte lands at addressed byte
// RULE6: right doubleword store never faults on alignment
// RULE7: length is eight minus offset, lanes shifted
// RULE8: halfword store writes low sixteen data bits
// RULE9: odd halfword address raises address error
// RULE10: immediate left shift, zero fill, sign extend
// RULE11: zero shift truncates and sign extends
// RULE12: variable shift uses low five count bits
// RULE13: signed compare writes one or zero
// RULE14: signed compare never raises overflow
// RULE15: translation faults reported, write suppressed on fault
package sscx_pkg;
  localparam logic [5:0] SSCX_OP_SDWR    = 6'h2d;
  localparam logic [5:0] SSCX_OP_SHALF   = 6'h29;
  localparam logic [5:0] SSCX_OP_SPECIAL = 6'h00;
  localparam logic [5:0] SSCX_FN_SLLI    = 6'h00;
  localparam logic [5:0] SSCX_FN_SHIFT_LEFT_WORD_VAR    = 6'h04;
  localparam logic [5:0] SSCX_FN_SLTS    = 6'h2a;
  localparam int SSCX_OPC_LSB  = 26;
  localparam int SSCX_BASE_LSB = 21;
  localparam int SSCX_RT_LSB   = 16;
  localparam int SSCX_RD_LSB   = 11;
  localparam int SSCX_SA_LSB   = 6;
  localparam logic [3:0] SSCX_DWORD_LEN = 4'h8;
  localparam logic [3:0] SSCX_HALF_LEN  = 4'h2;
  typedef enum logic [2:0] {
    SSCX_EXC_NONE   = 3'b000,
    SSCX_EXC_ADEL   = 3'b001,
    SSCX_EXC_REFILL = 3'b010,
    SSCX_EXC_INVAL  = 3'b011,
    SSCX_EXC_MOD    = 3'b100
  } sscx_exc_t;
endpackage : sscx_pkg

//--- sscx_shift_cmp.sv
`timescale 1ns/1ps
// combinational word shift and signed compare
module sscx_shift_cmp
  import sscx_pkg::*;
(
  input  wire logic [63:0] i_src_s,    // first source value
  input  wire logic [63:0] i_src_t,    // second source value
  input  wire logic [4:0]  i_amt,      // shift count
  output logic      [63:0] o_shl,      // sign-extended shifted word
  output logic      [63:0] o_slt       // compare result
);
  logic [31:0] word_sh;

  // only low word is used, so unextended sources still give valid results
  assign word_sh = i_src_t[31:0] << i_amt;                  // see RULE10
  assign o_shl   = {{32{word_sh[31]}}, word_sh};           // see RULE11
  // signed compare without subtraction: no overflow can arise
  assign o_slt   = {63'h0,                                 // see RULE14
                    ($signed(i_src_s) < $signed(i_src_t))}; // see RULE13
endmodule : sscx_shift_cmp

//--- sscx_exec_props.sv
`timescale 1ns/1ps
// watches store, fault, immediate shift and compare results against the issued word and its operands
module sscx_exec_props
  import sscx_pkg::*;
(
  input wire logic        i_clk_sys, i_resetn, i_valid, i_big_endian,
  input wire logic        i_tlb_refill, i_tlb_invalid, i_tlb_mod,
  input wire logic [31:0] i_instr,
  input wire logic [63:0] i_rs_data, i_rt_data,
  input wire logic [4:0]  o_rs_idx, o_rt_idx,
  input wire logic        o_wb_en, o_mem_wr, o_exc,
  input wire logic [63:0] o_wb_data,
  input wire logic [31:0] o_mem_vaddr,
  input wire logic [3:0]  o_mem_len,
  input sscx_exc_t        o_exc_code
);
  logic [31:0] ea, sh32;
  logic [3:0]  len_exp;
  logic        store_dword_right, half, spc, tlb, lt;
  // decode and reference values, sampled one edge before the answer
  assign ea = i_rs_data[31:0] + {{16{i_instr[15]}}, i_instr[15:0]};
  assign len_exp = 4'h8 - {1'b0, ea[2:0] ^ {3{i_big_endian}}};
  assign store_dword_right = i_valid && i_instr[31:26] == SSCX_OP_SDWR;
  assign half = i_valid && i_instr[31:26] == SSCX_OP_SHALF;
  assign spc = i_valid && i_instr[31:26] == SSCX_OP_SPECIAL;
  assign tlb = i_tlb_refill | i_tlb_invalid | i_tlb_mod;
  assign sh32 = i_rt_data[31:0] << i_instr[10:6];
  assign lt = $signed(i_rs_data) < $signed(i_rt_data);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  property p_idx; o_rs_idx == i_instr[25:21] && o_rt_idx == i_instr[20:16];
  endproperty
  a_idx: assert property (p_idx) else $error("read index wrong");
  property p_sdr_wr; store_dword_right && !tlb |=> o_mem_wr && !o_exc; endproperty
  a_sdr_wr: assert property (p_sdr_wr) else $error("store lost");
  property p_sdr_len; store_dword_right && !tlb |=> o_mem_len == $past(len_exp); endproperty
  a_sdr_len: assert property (p_sdr_len) else $error("bad length");
  property p_sdr_addr; store_dword_right && !tlb |=> o_mem_vaddr == $past(ea); endproperty
  a_sdr_addr: assert property (p_sdr_addr) else $error("bad addr");
  property p_half_err;
    half && ea[0] |=> o_exc && o_exc_code == SSCX_EXC_ADEL && !o_mem_wr;
  endproperty
  a_half_err: assert property (p_half_err) else $error("odd half");
  property p_tlb; (store_dword_right || half && !ea[0]) && tlb |=> o_exc && !o_mem_wr;
  endproperty
  a_tlb: assert property (p_tlb) else $error("fault not taken");
  property p_shl; spc && i_instr[5:0] == SSCX_FN_SLLI |=> o_wb_en &&
    o_wb_data == {{32{$past(sh32[31])}}, $past(sh32)}; endproperty
  a_shl: assert property (p_shl) else $error("shift wrong");
  property p_slt; spc && i_instr[5:0] == SSCX_FN_SLTS |=> o_wb_en &&
    !o_exc && o_wb_data == {63'h0, $past(lt)}; endproperty
  a_slt: assert property (p_slt) else $error("compare wrong");
endmodule : sscx_exec_props

bind sscx_exec sscx_exec_props u_props (.i_clk_sys, .i_resetn, .i_valid,
  .i_big_endian, .i_tlb_refill, .i_tlb_invalid, .i_tlb_mod, .i_instr,
  .i_rs_data, .i_rt_data, .o_rs_idx, .o_rt_idx, .o_wb_en, .o_mem_wr, .o_exc,
  .o_wb_data, .o_mem_vaddr, .o_mem_len, .o_exc_code);

//--- sscx_gpr_model.sv
`timescale 1ns/1ps
// register file answering reads in the same cycle
module sscx_gpr_model (
  input  wire logic [4:0]  i_rs_idx,  // first read index
  input  wire logic [4:0]  i_rt_idx,  // second read index
  output logic      [63:0] o_rs_data, // first read value
  output logic      [63:0] o_rt_data  // second read value
);
  logic [63:0] gpr [32];
  // unwritten entries hold a pattern so a wrong index never reads zero
  initial for (int i = 0; i < 32; i++) gpr[i] = 64'haaaa_5555_aaaa_5555;
  assign o_rs_data = gpr[i_rs_idx];
  assign o_rt_data = gpr[i_rt_idx];
endmodule : sscx_gpr_model

//--- sscx_exec_tb.sv
`timescale 1ns/1ps
module sscx_exec_tb
  import sscx_pkg::*;
;
  logic i_clk_sys = 0, i_resetn = 0, i_valid = 0, i_big_endian = 0;
  logic i_tlb_refill = 0, i_tlb_invalid = 0, i_tlb_mod = 0;
  logic [31:0] i_instr = 0, o_mem_vaddr;
  logic [63:0] i_rs_data, i_rt_data, o_wb_data;
  logic [4:0] o_rs_idx, o_rt_idx, o_wb_idx;
  logic o_wb_en, o_mem_wr, o_exc;
  logic [3:0] o_mem_len;
  logic [127:0] o_mem_data;
  logic [15:0] o_mem_be;
  sscx_exc_t o_exc_code;
  int miscompares = 0, n_checks = 0;
  sscx_exec DUT (
    .i_clk_sys     (i_clk_sys),
    .i_resetn      (i_resetn),
    .i_valid       (i_valid),
    .i_instr       (i_instr),
    .i_rs_data     (i_rs_data),
    .i_rt_data     (i_rt_data),
    .i_big_endian  (i_big_endian),
    .i_tlb_refill  (i_tlb_refill),
    .i_tlb_invalid (i_tlb_invalid),
    .i_tlb_mod     (i_tlb_mod),
    .o_rs_idx      (o_rs_idx),
    .o_rt_idx      (o_rt_idx),
    .o_wb_en       (o_wb_en),
    .o_wb_idx      (o_wb_idx),
    .o_wb_data     (o_wb_data),
    .o_mem_wr      (o_mem_wr),
    .o_mem_vaddr   (o_mem_vaddr),
    .o_mem_len     (o_mem_len),
    .o_mem_data    (o_mem_data),
    .o_mem_be      (o_mem_be),
    .o_exc         (o_exc),
    .o_exc_code    (o_exc_code)
  );
  sscx_gpr_model u_gpr (.i_rs_idx(o_rs_idx), .i_rt_idx(o_rt_idx),
    .o_rs_data(i_rs_data), .o_rt_data(i_rt_data));
  always #20 i_clk_sys = ~i_clk_sys;
  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one instruction, then sample the registered answer mid-cycle
  task automatic issue(logic [31:0] w, logic [63:0] s, t, logic [3:0] f);
    @(posedge i_clk_sys);
    u_gpr.gpr[1] <= s;
    u_gpr.gpr[2] <= t;
    {i_big_endian, i_tlb_mod, i_tlb_invalid, i_tlb_refill} <= f;
    i_instr <= w;
    i_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_valid <= 1'b0;
    @(negedge i_clk_sys);
  endtask : issue
  task automatic t_sdr(logic bg);
    logic [2:0] b;
    logic hi;
    logic [63:0] d;
    logic [7:0] m;
    for (int e = 0; e < 16; e++) begin
      b = 3'(e) ^ {3{bg}};
      hi = e[3] ^ bg;
      d = 64'h0807_0605_0403_0201 << (8 * b);
      m = 8'hff << b;
      issue({6'h2d, 10'h022, 16'hfff0}, 64'h1010 + e,
        64'h0807_0605_0403_0201, {bg, 3'h0});
      chk("wr", 1, o_mem_wr);
      chk("len", 8 - b, o_mem_len);
      chk("addr", 32'h1000 + e, o_mem_vaddr);
      chk("data", hi ? {d, 64'h0} : {64'h0, d}, o_mem_data);
      chk("be", hi ? {m, 8'h0} : {8'h0, m}, o_mem_be);
    end
  endtask : t_sdr
  task automatic t_store_faults;
    issue({6'h29, 10'h022, 16'h0006}, 0, 64'h1111_2222_3333_beef, 0);
    chk("hlen", 2, o_mem_len);
    chk("hdata", 16'hbeef, o_mem_data[63:48]);
    chk("hwr", {1'b1, 16'h00c0}, {o_mem_wr, o_mem_be});
    issue({6'h29, 10'h022, 16'h0007}, 0, 0, 0);
    chk("hcode", {2'b10, SSCX_EXC_ADEL},
      {o_exc, o_mem_wr, o_exc_code});
    for (int k = 0; k < 3; k++) begin
      issue({6'h2d, 10'h022, 16'h0000}, 64'h1013, 0, 4'(1 << k));
      chk("tlb", {2'b10, 3'(k + 2)},
        {o_exc, o_mem_wr, o_exc_code});
    end
  endtask : t_store_faults
  task automatic t_alu;
    // rt is register 2, rd is register 3, count field in bits 10..6
    issue({21'h43, 5'd0, 6'h00}, 0, 64'h1234_5678_8000_0001, 0);
    chk("sll0", {1'b1, 5'd3, 64'hffff_ffff_8000_0001},
      {o_wb_en, o_wb_idx, o_wb_data});
    issue({21'h43, 5'd31, 6'h00}, 0, 64'h3, 0);
    chk("sll31", 64'hffff_ffff_8000_0000, o_wb_data);
    issue({6'h00, 10'h022, 5'd3, 5'd0, 6'h04}, 64'h25, 64'h0400_0001, 0);
    chk("shift_left_word_var", 64'hffff_ffff_8000_0020, o_wb_data);
    issue({6'h00, 10'h022, 5'd3, 5'd0, 6'h2a}, 64'h7fff_ffff_ffff_ffff,
      64'h8000_0000_0000_0000, 0);
    chk("slt0", 2'b00, {o_exc, o_wb_data[0]});
    issue({6'h00, 10'h022, 5'd3, 5'd0, 6'h2a}, 64'h8000_0000_0000_0000,
      64'h1, 0);
    chk("slt1", 64'h1, o_wb_data);
    issue({6'h3f, 26'h0}, 0, 0, 0);
    chk("none", 0, {o_wb_en, o_mem_wr, o_exc});
  endtask : t_alu
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  // watchdog well beyond the 43 instructions issued
  initial begin
    repeat (3000) @(posedge i_clk_sys);
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    t_sdr(0);
    t_sdr(1);
    t_store_faults;
    t_alu;
    finish_test;
  end
endmodule : sscx_exec_tb
